// [rtl/pdc_pkg.sv]
// Purpose: Shared constants and types for the PLL divider and output enable block.
// Assumes: 32-bit plain register port, 100 MHz core_clk.
// Notes: Offsets are byte addresses of word registers.
// Functional notes
// - Global output enable low forces the eight clock outputs off but leaves the tap output alone; high means normal operation.
// - Tap port enable one drives the tap output; zero (reset) keeps it disabled.
// - Each write of the feedback configuration word starts frequency calibration.
// - Feedback divider is 18-bit binary, codes 1..262143 valid, zero invalid, default 760.
// - Post-oscillator divider always in feedback; total division is their product.
// - Post-oscillator divider codes 2..8 divide by code, default 2; others invalid.
// - Pump gain code 0,1,2,3 gives 1x (default), 4x, 16x, 32x.
// - Per-output enable one runs output only with global enable and gate pin high.
package pdc_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_OUT = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] FBCFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    // Control word fields
    localparam int CTRL_GLOB_BIT = 0;
    localparam int CTRL_TAP_BIT = 1;
    localparam int CTRL_PER_LSB = 8;
    // Feedback configuration word fields
    localparam int FB_N_LSB = 0;
    localparam int FB_VCO_LSB = 18;
    localparam int FB_GAIN_LSB = 22;
    // Status word fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_INVALID_BIT = 1;
    localparam int ST_GATE_BIT = 2;
    localparam int ST_CLKEN_LSB = 8;
    // Reset values, post-oscillator divider code limits and pump gain multipliers
    localparam logic GLOB_RST = 1'b1;
    localparam logic TAP_RST = 1'b0;
    localparam logic [7:0] PER_RST = 8'h00;
    localparam logic [17:0] N_RST = 18'h002F8;
    localparam logic [3:0] VCO_RST = 4'h2;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [3:0] VCO_MIN = 4'h2;
    localparam logic [3:0] VCO_MAX = 4'h8;
    localparam logic [5:0] GAIN_X1 = 6'h01;
    localparam logic [5:0] GAIN_X4 = 6'h04;
    localparam logic [5:0] GAIN_X16 = 6'h10;
    localparam logic [5:0] GAIN_X32 = 6'h20;
    // Calibration run length in core_clk cycles
    localparam logic [7:0] CAL_CYCLES = 8'h40;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN = 2'b10
    } pdc_cal_type;
endpackage : pdc_pkg

// [rtl/pdc_pin_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for an asynchronous pin.
// Assumes: Pin level is slow compared to core_clk.
// Notes: Level changes only once the second and third stages agree.
`timescale 1ns/1ps
module pdc_pin_sync
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pdc_sync_type;

    pdc_sync_type st_q;
    pdc_sync_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, lvl: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
endmodule : pdc_pin_sync

// [rtl/pdc_cfg.sv]
// Purpose: Feedback divider, post-oscillator divider, pump gain and output enable configuration.
// Assumes: Gate pin is pulled high on the board when left unconnected.
// Notes: Invalid divider codes are stored and flagged, not corrected.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module pdc_cfg
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins
    input wire logic output_gate_pin,
    output logic [NUM_OUT-1:0] clk_out_enable,
    output logic tap_out_enable,
    // PLL settings
    output logic [17:0] fb_divider,
    output logic [3:0] post_osc_divider,
    output logic [1:0] pump_gain_select,
    output logic [5:0] pump_gain_mult,
    output logic [21:0] fb_total_div,
    output logic cfg_invalid,
    // Calibration
    output logic cal_start,
    output logic cal_busy
);
    typedef struct packed {
        logic glob_en;
        logic tap_en;
        logic [NUM_OUT-1:0] per_en;
        logic [17:0] n_div;
        logic [3:0] vco_div;
        logic [1:0] gain;
        logic [NUM_OUT-1:0] clk_en;
        logic tap_out;
        logic [5:0] gain_mult;
        logic [21:0] fb_total;
        logic invalid;
        logic cal_start;
        pdc_cal_type cal_st;
        logic [7:0] cal_cnt;
        logic [31:0] rdata;
    } pdc_state_type;

    pdc_state_type st_q;
    pdc_state_type st_d;
    logic gate_lvl;

    function automatic logic [5:0] gain_mult_of(input logic [1:0] code);
        case (code)
            2'h0: gain_mult_of = GAIN_X1;
            2'h1: gain_mult_of = GAIN_X4;
            2'h2: gain_mult_of = GAIN_X16;
            default: gain_mult_of = GAIN_X32;
        endcase
    endfunction : gain_mult_of

    function automatic logic fb_bad(input logic [17:0] n, input logic [3:0] v);
        fb_bad = (n == 18'h00000) || (v < VCO_MIN) || (v > VCO_MAX);
    endfunction : fb_bad

    function automatic logic [21:0] fb_product(input logic [17:0] n, input logic [3:0] v);
        fb_product = 22'(n) * 22'(v);
    endfunction : fb_product

    pdc_pin_sync u_gate_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(output_gate_pin),
        .level(gate_lvl)
    );

    logic wr_ctrl;
    logic wr_fb;
    assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
    assign wr_fb = reg_wr && (reg_addr == FBCFG_OFS);

    always_comb begin
        st_d = st_q;
        st_d.cal_start = 1'b0;
        st_d.rdata = 32'h00000000;
        if (wr_ctrl) begin
            st_d.glob_en = reg_wdata[CTRL_GLOB_BIT];
            st_d.tap_en = reg_wdata[CTRL_TAP_BIT];
            st_d.per_en = reg_wdata[CTRL_PER_LSB +: NUM_OUT];
        end
        if (wr_fb) begin
            st_d.n_div = reg_wdata[FB_N_LSB +: 18];
            st_d.vco_div = reg_wdata[FB_VCO_LSB +: 4];
            st_d.gain = reg_wdata[FB_GAIN_LSB +: 2];
        end
        // Calibration restarts on every write of the feedback word
        case (st_q.cal_st)
            CAL_IDLE: begin
                if (wr_fb) begin
                    st_d.cal_start = 1'b1;
                    st_d.cal_st = CAL_RUN;
                    st_d.cal_cnt = CAL_CYCLES;
                end
            end
            CAL_RUN: begin
                if (wr_fb) begin
                    st_d.cal_start = 1'b1;
                    st_d.cal_cnt = CAL_CYCLES;
                end else if (st_q.cal_cnt == 8'h01) begin
                    st_d.cal_st = CAL_IDLE;
                    st_d.cal_cnt = 8'h00;
                end else begin
                    st_d.cal_cnt = st_q.cal_cnt - 8'h01;
                end
            end
            default: begin
                st_d.cal_st = CAL_IDLE;
                st_d.cal_cnt = 8'h00;
            end
        endcase
        st_d.clk_en = st_d.per_en & {NUM_OUT{st_d.glob_en & gate_lvl}};
        st_d.tap_out = st_d.tap_en;
        st_d.gain_mult = gain_mult_of(st_d.gain);
        st_d.fb_total = fb_product(st_d.n_div, st_d.vco_div);
        st_d.invalid = fb_bad(st_d.n_div, st_d.vco_div);
        if (reg_rd) begin
            case (reg_addr)
                CTRL_OFS: begin
                    st_d.rdata[CTRL_GLOB_BIT] = st_q.glob_en;
                    st_d.rdata[CTRL_TAP_BIT] = st_q.tap_en;
                    st_d.rdata[CTRL_PER_LSB +: NUM_OUT] = st_q.per_en;
                end
                FBCFG_OFS: begin
                    st_d.rdata[FB_N_LSB +: 18] = st_q.n_div;
                    st_d.rdata[FB_VCO_LSB +: 4] = st_q.vco_div;
                    st_d.rdata[FB_GAIN_LSB +: 2] = st_q.gain;
                end
                STATUS_OFS: begin
                    st_d.rdata[ST_BUSY_BIT] = (st_q.cal_st == CAL_RUN);
                    st_d.rdata[ST_INVALID_BIT] = st_q.invalid;
                    st_d.rdata[ST_GATE_BIT] = gate_lvl;
                    st_d.rdata[ST_CLKEN_LSB +: NUM_OUT] = st_q.clk_en;
                end
                default: begin
                    st_d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{glob_en: GLOB_RST, tap_en: TAP_RST, per_en: PER_RST,
                      n_div: N_RST, vco_div: VCO_RST, gain: GAIN_RST,
                      clk_en: 8'h00, tap_out: TAP_RST, gain_mult: GAIN_X1,
                      fb_total: 22'h0005F0, invalid: 1'b0, cal_start: 1'b0,
                      cal_st: CAL_IDLE, cal_cnt: 8'h00, rdata: 32'h00000000};
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign clk_out_enable = st_q.clk_en;
    assign tap_out_enable = st_q.tap_out;
    assign fb_divider = st_q.n_div;
    assign post_osc_divider = st_q.vco_div;
    assign pump_gain_select = st_q.gain;
    assign pump_gain_mult = st_q.gain_mult;
    assign fb_total_div = st_q.fb_total;
    assign cfg_invalid = st_q.invalid;
    assign cal_start = st_q.cal_start;
    // Run bit of the one-hot code, so the output comes straight from a flop
    assign cal_busy = st_q.cal_st[1];

    a_global_off: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl && !reg_wdata[CTRL_GLOB_BIT] |=> clk_out_enable == 8'h00)
        else $error("outputs not all off with global enable low");

    a_tap_follow: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> tap_out_enable == $past(reg_wdata[CTRL_TAP_BIT]))
        else $error("tap output enable does not follow written bit");

    a_cal_launch: assert property (@(posedge core_clk) disable iff (rst)
        wr_fb |=> cal_start && cal_busy)
        else $error("feedback word write did not start calibration");

    a_cal_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !wr_fb |=> !cal_start)
        else $error("calibration started without feedback write");

    a_n_zero_bad: assert property (@(posedge core_clk) disable iff (rst)
        wr_fb && reg_wdata[FB_N_LSB +: 18] == 18'h00000 |=> cfg_invalid)
        else $error("zero feedback divider not flagged");

    a_total_div: assert property (@(posedge core_clk) disable iff (rst)
        fb_total_div == 22'(fb_divider) * 22'(post_osc_divider))
        else $error("total feedback division wrong");

    a_vco_range: assert property (@(posedge core_clk) disable iff (rst)
        wr_fb && reg_wdata[FB_N_LSB +: 18] != 18'h00000 && reg_wdata[FB_VCO_LSB +: 4] == 4'h9 |=> cfg_invalid)
        else $error("post divider code 9 not flagged");

    a_gain_map: assert property (@(posedge core_clk) disable iff (rst)
        pump_gain_select == 2'h2 |-> pump_gain_mult == 6'h10)
        else $error("pump gain code 2 not sixteen times");

    a_gate_mask: assert property (@(posedge core_clk) disable iff (rst)
        !gate_lvl |=> clk_out_enable == 8'h00)
        else $error("output enabled with gate pin low");

    a_per_mask: assert property (@(posedge core_clk) disable iff (rst)
        (clk_out_enable & ~st_q.per_en) == 8'h00)
        else $error("output enabled without its own enable");

    a_glob_normal: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl && reg_wdata[CTRL_GLOB_BIT] && gate_lvl |=>
        clk_out_enable == $past(reg_wdata[CTRL_PER_LSB +: NUM_OUT]))
        else $error("outputs do not follow per-output enables");

    a_fb_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_fb |=> fb_divider == $past(reg_wdata[FB_N_LSB +: 18]) &&
        post_osc_divider == $past(reg_wdata[FB_VCO_LSB +: 4]))
        else $error("feedback word fields not stored");

    a_reset_dflt: assert property (@(posedge core_clk) disable iff (rst)
        $past(rst) |-> fb_divider == 18'h002F8 && post_osc_divider == 4'h2 && !tap_out_enable && pump_gain_select == 2'h0)
        else $error("defaults not loaded at reset");
endmodule : pdc_cfg

// [verification/pdc_cfg_tb.sv]
// Purpose: Self-checking bench for the feedback divider, pump gain and output enable configuration.
// Assumes: Bench drives the register port and gate pin itself; no far-side model.
// Notes: Table rows cover the feedback word codes, hand-written tests cover gating, calibration and reset.
`timescale 1ns/1ps
module pdc_cfg_tb;
    import pdc_pkg::*;
    typedef struct {
        logic [17:0] n;
        logic [3:0] v;
        logic [1:0] g;
        logic [5:0] mult;
        logic inv;
    } pdc_row_type;
    logic core_clk, rst, reg_wr, reg_rd, output_gate_pin, tap_out_enable, cfg_invalid, cal_start, cal_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [NUM_OUT-1:0] clk_out_enable;
    logic [17:0] fb_divider;
    logic [3:0] post_osc_divider;
    logic [1:0] pump_gain_select;
    logic [5:0] pump_gain_mult;
    logic [21:0] fb_total_div;
    int bad_count, checks, cycles, cnt;
    pdc_row_type rows [8] = '{'{18'h00001, 4'h2, 2'h0, GAIN_X1, 1'b0}, '{18'h3FFFF, 4'h8, 2'h3, GAIN_X32, 1'b0},
        '{18'h002F8, 4'h3, 2'h1, GAIN_X4, 1'b0}, '{18'h00000, 4'h5, 2'h2, GAIN_X16, 1'b1},
        '{18'h00005, 4'h1, 2'h0, GAIN_X1, 1'b1}, '{18'h00005, 4'h9, 2'h1, GAIN_X4, 1'b1},
        '{18'h00007, 4'hF, 2'h2, GAIN_X16, 1'b1}, '{18'h0000A, 4'h0, 2'h3, GAIN_X32, 1'b1}};

    pdc_cfg DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .output_gate_pin,
        .clk_out_enable, .tap_out_enable, .fb_divider, .post_osc_divider, .pump_gain_select, .pump_gain_mult,
        .fb_total_div, .cfg_invalid, .cal_start, .cal_busy);

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    task automatic chk_flag(input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_flag

    task automatic end_of_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Strobes are raised just after an edge and dropped at the edge that samples them
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic cycles_wait(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cycles_wait

    task automatic defaults;
        chk(32'h2F8, 32'(fb_divider));
        chk(32'h2, 32'(post_osc_divider));
        chk(32'h0, 32'(pump_gain_select));
        chk(32'h1, 32'(pump_gain_mult));
        chk(32'h5F0, 32'(fb_total_div));
        chk(32'h0, {23'h0, tap_out_enable, clk_out_enable});
        chk(32'h0, {29'h0, cfg_invalid, cal_start, cal_busy});
    endtask : defaults

    // Counts cycles from the first busy cycle until busy drops
    task automatic busy_len;
        cnt = 0;
        while (cal_busy === 1'b1 && cnt < 200) begin
            cycles_wait(1);
            cnt++;
        end
    endtask : busy_len

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        output_gate_pin = 1'b1;
        repeat (10) @(posedge core_clk);
        defaults();
        rst <= 1'b0;
        cycles_wait(1);
        defaults();
        rd(CTRL_OFS);
        chk(32'h1, d);
        foreach (rows[i]) begin
            wr(FBCFG_OFS, {8'h00, rows[i].g, rows[i].v, rows[i].n});
            chk_flag(1'b1, cal_start);
            chk(32'(rows[i].n), 32'(fb_divider));
            chk(32'(rows[i].v), 32'(post_osc_divider));
            chk({30'h0, rows[i].g}, 32'(pump_gain_select));
            chk(32'(rows[i].mult), 32'(pump_gain_mult));
            chk(32'(rows[i].n) * 32'(rows[i].v), 32'(fb_total_div));
            chk_flag(rows[i].inv, cfg_invalid);
            cycles_wait(1);
            chk_flag(1'b0, cal_start);
        end
        busy_len();
        wr(FBCFG_OFS, 32'h000802F8);
        busy_len();
        chk(32'h40, cnt);
        wr(FBCFG_OFS, 32'h000802F8);
        rd(STATUS_OFS);
        chk(32'h5, d & 32'h7);
        cycles_wait(28);
        // Rewrite as the host does after a reference divider change
        wr(FBCFG_OFS, 32'h000802F8);
        chk_flag(1'b1, cal_start);
        busy_len();
        chk(32'h40, cnt);
        wr(8'h0C, 32'hFFFFFFFF);
        wr(STATUS_OFS, 32'hFFFFFFFF);
        chk_flag(1'b0, cal_start);
        chk(32'h2F8, 32'(fb_divider));
        rd(8'h0C);
        chk(32'h0, d);
        rd(CTRL_OFS);
        chk(32'h1, d);
        cycles_wait(1);
        chk(32'h0, reg_rdata);
        wr(CTRL_OFS, 32'h0000A503);
        cycles_wait(1);
        chk(32'hA5, 32'(clk_out_enable));
        chk_flag(1'b1, tap_out_enable);
        wr(CTRL_OFS, 32'h0000A500);
        cycles_wait(1);
        chk(32'h0, 32'(clk_out_enable));
        chk_flag(1'b0, tap_out_enable);
        wr(CTRL_OFS, 32'h0000A501);
        // Gate pin driven as a lock indicator would on loss of lock
        output_gate_pin <= 1'b0;
        cycles_wait(6);
        chk(32'h0, 32'(clk_out_enable));
        rd(STATUS_OFS);
        chk(32'h0, d & 32'h0000FF04);
        output_gate_pin <= 1'b1;
        cycles_wait(6);
        chk(32'hA5, 32'(clk_out_enable));
        rst <= 1'b1;
        cycles_wait(1);
        defaults();
        rst <= 1'b0;
        cycles_wait(1);
        defaults();
        end_of_test();
    end
endmodule : pdc_cfg_tb
